// ==== design/async_serial_port_with_dma.sv ====
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ns
module async_serial_port_with_dma
  import uart_pkg::*;
#(
  parameter int addr_width = 8
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [addr_width-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [addr_width-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic serial_in,
  output logic serial_out,
  output logic tx_dma_req,
  input wire logic tx_dma_ack,
  input wire logic [8:0] tx_dma_data,
  output logic rx_dma_req,
  input wire logic rx_dma_ack,
  output logic [8:0] rx_dma_data,
  output logic dma_low_priority,
  output logic autobaud_edge,
  output logic irq
);

  if (addr_width < 7) begin : g_width_check
    $error("addr_width too small for register map");
  end

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] div_low_reg;
  logic [7:0] div_high_reg;
  frame_cfg_type cfg_reg;
  logic [3:0] int_status_reg;
  logic [3:0] int_mask_reg;
  logic [3:0] control_reg;
  logic [15:0] capture_reg;

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  logic aw_held_reg;
  logic w_held_reg;
  logic [addr_width-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_fire;
  logic wr_hit;

  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign wr_fire = aw_held_reg && w_held_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= axi_okay;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? axi_okay : axi_slverr;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  function automatic logic is_mapped(input logic [addr_width-1:0] a);
    logic [7:0] b;
    b = 8'(a);
    is_mapped = (a[addr_width-1:6] == '0) && (b[1:0] == 2'b00) && (b <= addr_capture);
  endfunction

  assign wr_hit = is_mapped(awaddr_reg);

  function automatic logic wr_to(input logic [7:0] a);
    wr_to = wr_fire && (8'(awaddr_reg) == a) && wstrb_reg[0];
  endfunction

  // ****************************************
  // Baud tick generator
  // ****************************************
  logic [15:0] divisor;
  logic [15:0] baud_count_reg;
  logic tick;
  logic div_write;

  assign divisor = {div_high_reg, div_low_reg};
  assign div_write = wr_to(addr_divisor_low) || wr_to(addr_divisor_high);
  assign tick = (baud_count_reg == 16'h0000);

  // Tick every divisor clocks; bit rate clock/(16*divisor)
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      baud_count_reg <= 16'h0000;
    end else if (div_write) begin
      baud_count_reg <= 16'h0000; // Restart so a new rate applies at once
    end else if (tick) begin
      baud_count_reg <= (divisor == 16'h0000) ? 16'h0000 : divisor - 16'h0001;
    end else begin
      baud_count_reg <= baud_count_reg - 16'h0001;
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_low_reg <= reset_divisor_low;
      div_high_reg <= reset_divisor_high;
      cfg_reg <= frame_cfg_type'(reset_line_control[6:0]);
      int_mask_reg <= reset_int_mask;
      control_reg <= reset_control;
    end else begin
      if (wr_to(addr_divisor_low)) div_low_reg <= wdata_reg[7:0];
      if (wr_to(addr_divisor_high)) div_high_reg <= wdata_reg[7:0];
      if (wr_to(addr_line_control)) cfg_reg <= frame_cfg_type'(wdata_reg[6:0]);
      if (wr_to(addr_int_mask)) int_mask_reg <= wdata_reg[3:0];
      if (wr_to(addr_control)) control_reg <= wdata_reg[3:0];
    end
  end

  // ****************************************
  // Transmit path: holding register plus shifter
  // ****************************************
  logic tx_hold_full_reg;
  logic [8:0] tx_hold_reg;
  logic tx_busy;
  logic tx_load;
  logic tx_cpu_write;
  logic tx_dma_take;

  assign tx_cpu_write = wr_to(addr_data) && !control_reg[ctl_tx_dma];
  assign tx_dma_req = control_reg[ctl_tx_dma] && !tx_hold_full_reg;
  assign tx_dma_take = tx_dma_req && tx_dma_ack;
  assign tx_load = tx_hold_full_reg && !tx_busy;

  // Word waits in holding stage while shifter sends the previous
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_hold_full_reg <= 1'b0;
      tx_hold_reg <= 9'h000;
    end else if (tx_cpu_write && !tx_hold_full_reg) begin
      tx_hold_full_reg <= 1'b1;
      tx_hold_reg <= {cfg_reg.ninth_val | wdata_reg[8], wdata_reg[7:0]};
    end else if (tx_dma_take) begin
      tx_hold_full_reg <= 1'b1;
      tx_hold_reg <= tx_dma_data;
    end else if (tx_load) begin
      tx_hold_full_reg <= 1'b0;
    end
  end

  serial_tx u_tx (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick),
    .cfg(cfg_reg),
    .load(tx_load),
    .word(tx_hold_reg),
    .busy(tx_busy),
    .line_out(serial_out)
  );

  // ****************************************
  // Receive path: shifter plus holding register
  // ****************************************
  logic rx_done;
  rx_char_type rx_char;
  logic rx_full_reg;
  rx_char_type rx_hold_reg;
  logic rx_overrun_reg;
  logic rx_cpu_read;
  logic rx_accept;
  logic rx_is_addr;

  // Receiver runs beside transmitter, sharing only the baud tick and cfg_reg
  serial_rx u_rx (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick),
    .cfg(cfg_reg),
    .line_in(serial_in),
    .done(rx_done),
    .char_out(rx_char)
  );

  assign rx_is_addr = cfg_reg.ninth_en && rx_char.word[8];
  assign rx_accept = rx_done && (!control_reg[ctl_addr_filter] || rx_is_addr);
  assign rx_dma_req = control_reg[ctl_rx_dma] && rx_full_reg;
  assign rx_dma_data = rx_hold_reg.word;
  assign dma_low_priority = 1'b1;

  // New character lands in holding stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_full_reg <= 1'b0;
      rx_hold_reg <= '0;
      rx_overrun_reg <= 1'b0;
    end else begin
      if (wr_to(addr_status) && wdata_reg[4]) rx_overrun_reg <= 1'b0;
      if (rx_accept) begin
        rx_full_reg <= 1'b1;
        rx_hold_reg <= rx_char;
        if (rx_full_reg && !(rx_cpu_read || (rx_dma_req && rx_dma_ack))) begin
          rx_overrun_reg <= 1'b1;
        end
      end else if (rx_cpu_read || (rx_dma_req && rx_dma_ack)) begin
        rx_full_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // Autobaud edge capture
  // ****************************************
  logic line_prev_reg;
  logic [15:0] edge_count_reg;

  // Edge pulse for an external timer plus own interval count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_prev_reg <= 1'b1;
      edge_count_reg <= 16'h0000;
      capture_reg <= 16'h0000;
      autobaud_edge <= 1'b0;
    end else begin
      line_prev_reg <= serial_in;
      autobaud_edge <= control_reg[ctl_autobaud] && (line_prev_reg != serial_in);
      if (control_reg[ctl_autobaud] && line_prev_reg != serial_in) begin
        capture_reg <= edge_count_reg;
        edge_count_reg <= 16'h0001;
      end else if (edge_count_reg != 16'hffff) begin
        edge_count_reg <= edge_count_reg + 16'h0001;
      end
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  logic [3:0] int_events;

  assign int_events[irq_tx_empty] = tx_load;
  assign int_events[irq_rx_ready] = rx_accept;
  assign int_events[irq_rx_error] = rx_done && (rx_char.parity_err || rx_char.framing_err);
  assign int_events[irq_rx_address] = rx_done && rx_is_addr;

  // Set wins over write-one-to-clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_status_reg <= 4'h0;
    end else if (wr_to(addr_int_status)) begin
      int_status_reg <= (int_status_reg & ~wdata_reg[3:0]) | int_events;
    end else begin
      int_status_reg <= int_status_reg | int_events;
    end
  end

  assign irq = |(int_status_reg & int_mask_reg);

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  logic [31:0] rd_value;
  logic [7:0] rd_off;

  assign s_axi_arready = !s_axi_rvalid;
  assign rd_off = 8'(s_axi_araddr);
  assign rx_cpu_read = s_axi_arvalid && s_axi_arready && (rd_off == addr_data)
                       && is_mapped(s_axi_araddr) && !control_reg[ctl_rx_dma];

  always_comb begin
    rd_value = 32'h0000_0000;
    case (rd_off)
      addr_data: rd_value = {23'h0, rx_hold_reg.word};
      addr_divisor_low: rd_value = {24'h0, div_low_reg};
      addr_divisor_high: rd_value = {24'h0, div_high_reg};
      addr_line_control: rd_value = {25'h0, cfg_reg};
      addr_status: rd_value = {26'h0, rx_hold_reg.framing_err, rx_hold_reg.parity_err,
                               rx_overrun_reg, tx_busy, tx_hold_full_reg, rx_full_reg};
      addr_int_status: rd_value = {28'h0, int_status_reg};
      addr_int_mask: rd_value = {28'h0, int_mask_reg};
      addr_control: rd_value = {28'h0, control_reg};
      addr_capture: rd_value = {16'h0, capture_reg};
      default: rd_value = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= axi_okay;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= is_mapped(s_axi_araddr) ? rd_value : 32'h0000_0000;
      s_axi_rresp <= is_mapped(s_axi_araddr) ? axi_okay : axi_slverr;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ==== design/uart_pkg.sv ====
package uart_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] addr_data = 8'h00;
  localparam logic [7:0] addr_divisor_low = 8'h04;
  localparam logic [7:0] addr_divisor_high = 8'h08;
  localparam logic [7:0] addr_line_control = 8'h0c;
  localparam logic [7:0] addr_status = 8'h10;
  localparam logic [7:0] addr_int_status = 8'h14;
  localparam logic [7:0] addr_int_mask = 8'h18;
  localparam logic [7:0] addr_control = 8'h1c;
  localparam logic [7:0] addr_capture = 8'h20;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] reset_divisor_low = 8'h01;
  localparam logic [7:0] reset_divisor_high = 8'h00;
  localparam logic [7:0] reset_line_control = 8'h03;
  localparam logic [3:0] reset_int_mask = 4'h0;
  localparam logic [3:0] reset_control = 4'h0;

  // ****************************************
  // Line control fields
  // ****************************************
  localparam int lc_len_lsb = 0;
  localparam int lc_stop_bit = 2;
  localparam int lc_par_en_bit = 3;
  localparam int lc_par_even_bit = 4;
  localparam int lc_ninth_bit = 5;
  localparam int lc_ninth_val_bit = 6;

  // Interrupt status bits
  localparam int irq_tx_empty = 0;
  localparam int irq_rx_ready = 1;
  localparam int irq_rx_error = 2;
  localparam int irq_rx_address = 3;

  // Control bits
  localparam int ctl_tx_dma = 0;
  localparam int ctl_rx_dma = 1;
  localparam int ctl_addr_filter = 2;
  localparam int ctl_autobaud = 3;

  localparam logic [3:0] ticks_per_bit = 4'hf;
  localparam logic [3:0] mid_tick = 4'h7;
  localparam logic [1:0] axi_okay = 2'b00;
  localparam logic [1:0] axi_slverr = 2'b10;

  typedef struct packed {
    logic ninth_val;
    logic ninth_en;
    logic par_even;
    logic par_en;
    logic two_stop;
    logic [1:0] len;
  } frame_cfg_type;

  typedef struct packed {
    logic [8:0] word;
    logic parity_err;
    logic framing_err;
  } rx_char_type;

  function automatic logic [3:0] data_bits(input logic [1:0] len);
    data_bits = 4'h5 + {2'b00, len};
  endfunction

  function automatic logic calc_parity(input logic [8:0] w, input frame_cfg_type c);
    logic p;
    p = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (i < int'(data_bits(c.len)) || (i == 8 && c.ninth_en)) begin
        p = p ^ w[i];
      end
    end
    calc_parity = c.par_even ? p : ~p;
  endfunction

endpackage

// ==== design/serial_tx.sv ====
`timescale 1ns/1ns
module serial_tx
  import uart_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  input frame_cfg_type cfg,
  input wire logic load,
  input wire logic [8:0] word,
  output logic busy,
  output logic line_out
);

  typedef enum logic [1:0] {
    tx_idle = 2'b00,
    tx_shift = 2'b01,
    tx_stop = 2'b10
  } tx_state_type;

  tx_state_type state_reg;
  logic [10:0] shift_reg;
  logic [3:0] bits_reg;
  logic [3:0] tick_reg;
  logic [1:0] stop_reg;
  logic [8:0] word_reg;
  logic ninth_now;

  assign busy = (state_reg != tx_idle);
  assign ninth_now = cfg.ninth_en && (bits_reg == 4'h1 + {3'h0, cfg.par_en});

  // Start, LSB-first data, optional ninth and parity, stop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= tx_idle;
      shift_reg <= 11'h7ff;
      bits_reg <= 4'h0;
      tick_reg <= 4'h0;
      stop_reg <= 2'h0;
      line_out <= 1'b1;
    end else begin
      case (state_reg)
        tx_idle: begin
          line_out <= 1'b1;
          if (load) begin
            shift_reg <= {2'b11, word};
            bits_reg <= data_bits(cfg.len) + {3'h0, cfg.ninth_en} + {3'h0, cfg.par_en};
            tick_reg <= 4'h0;
            stop_reg <= cfg.two_stop ? 2'h2 : 2'h1;
            line_out <= 1'b0;
            state_reg <= tx_shift;
          end
        end
        tx_shift: if (tick) begin
          tick_reg <= tick_reg + 4'h1;
          if (tick_reg == ticks_per_bit) begin
            if (bits_reg == 4'h0) begin
              line_out <= 1'b1;
              state_reg <= tx_stop;
            end else begin
              line_out <= (bits_reg == 4'h1 && cfg.par_en) ? calc_parity(word_reg, cfg)
                          : ninth_now ? word_reg[8] : shift_reg[0];
              shift_reg <= {1'b1, shift_reg[10:1]};
              bits_reg <= bits_reg - 4'h1;
            end
          end
        end
        tx_stop: if (tick) begin
          tick_reg <= tick_reg + 4'h1;
          if (tick_reg == ticks_per_bit) begin
            stop_reg <= stop_reg - 2'h1;
            if (stop_reg == 2'h1) begin
              state_reg <= tx_idle;
            end
          end
        end
        default: state_reg <= tx_idle;
      endcase
    end
  end

  // Latched word for parity at the tail of the frame
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      word_reg <= 9'h000;
    end else if (load && state_reg == tx_idle) begin
      word_reg <= mask_word(word);
    end
  end

  function automatic logic [8:0] mask_word(input logic [8:0] w);
    logic [8:0] m;
    m = 9'h000;
    for (int i = 0; i < 8; i++) begin
      if (i < int'(data_bits(cfg.len))) begin
        m[i] = w[i];
      end
    end
    m[8] = cfg.ninth_en & w[8];
    mask_word = m;
  endfunction

endmodule

// ==== design/serial_rx.sv ====
`timescale 1ns/1ns
module serial_rx
  import uart_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  input frame_cfg_type cfg,
  input wire logic line_in,
  output logic done,
  output rx_char_type char_out
);

  typedef enum logic [1:0] {
    rx_idle = 2'b00,
    rx_start = 2'b01,
    rx_bits = 2'b10,
    rx_stopbit = 2'b11
  } rx_state_type;

  rx_state_type state_reg;
  logic [3:0] tick_reg;
  logic [3:0] count_reg;
  logic [3:0] total_reg;
  logic [9:0] bits_reg;

  function automatic logic [8:0] pick_word(input logic [9:0] b, input frame_cfg_type c);
    logic [8:0] w;
    w = 9'h000;
    for (int i = 0; i < 8; i++) begin
      if (i < int'(data_bits(c.len))) begin
        w[i] = b[i];
      end
    end
    if (c.ninth_en) begin
      w[8] = b[data_bits(c.len)];
    end
    pick_word = w;
  endfunction

  // Mid-bit sampling at sixteen ticks per bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= rx_idle;
      tick_reg <= 4'h0;
      count_reg <= 4'h0;
      total_reg <= 4'h0;
      bits_reg <= 10'h000;
      done <= 1'b0;
      char_out <= '0;
    end else begin
      done <= 1'b0;
      case (state_reg)
        rx_idle: if (!line_in) begin
          tick_reg <= 4'h0;
          state_reg <= rx_start;
        end
        rx_start: if (tick) begin
          tick_reg <= tick_reg + 4'h1;
          if (tick_reg == mid_tick) begin
            tick_reg <= 4'h0;
            count_reg <= 4'h0;
            total_reg <= data_bits(cfg.len) + {3'h0, cfg.ninth_en} + {3'h0, cfg.par_en};
            state_reg <= line_in ? rx_idle : rx_bits;
          end
        end
        rx_bits: if (tick) begin
          tick_reg <= tick_reg + 4'h1;
          if (tick_reg == ticks_per_bit) begin
            bits_reg[count_reg] <= line_in;
            count_reg <= count_reg + 4'h1;
            if (count_reg + 4'h1 == total_reg) begin
              state_reg <= rx_stopbit;
            end
          end
        end
        rx_stopbit: if (tick) begin
          tick_reg <= tick_reg + 4'h1;
          if (tick_reg == ticks_per_bit) begin
            // One stop bit checked; a second one reads as idle
            done <= 1'b1;
            char_out.word <= pick_word(bits_reg, cfg);
            char_out.parity_err <= cfg.par_en &&
              (bits_reg[total_reg - 4'h1] != calc_parity(pick_word(bits_reg, cfg), cfg));
            char_out.framing_err <= !line_in;
            state_reg <= rx_idle;
          end
        end
        default: state_reg <= rx_idle;
      endcase
    end
  end

endmodule

// ==== testbench/serial_peer.sv ====
`timescale 1ns/1ns
module serial_peer (
  input wire logic aclk,
  input wire logic line_from_dut,
  output logic line_to_dut
);
  // ****
  // Remote peer frames
  // ****
  initial line_to_dut = 1'b1;
  task automatic send(input logic [12:0] f, input int n, input int bt);
    for (int i = 0; i < n; i++) begin
      line_to_dut <= f[i];
      repeat (bt) @(posedge aclk);
    end
    line_to_dut <= 1'b1;
  endtask
  task automatic recv(output logic [12:0] f, input int n, input int bt);
    f = '1;
    for (int k = 0; k < 3000 && line_from_dut; k++) @(negedge aclk);
    repeat (bt / 2) @(negedge aclk);
    for (int i = 0; i < n; i++) begin
      f[i] = line_from_dut;
      repeat (bt) @(negedge aclk);
    end
  endtask
endmodule

// ==== testbench/async_serial_port_with_dma_sva.sv ====
`timescale 1ns/1ns
module async_serial_port_with_dma_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic serial_out,
  input wire logic tx_dma_req,
  input wire logic tx_dma_ack,
  input wire logic rx_dma_req,
  input wire logic rx_dma_ack,
  input wire logic dma_low_priority
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence start_low;
    (!serial_out) [*8];
  endsequence
  wr_answer_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  write_blocked_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  dma_priority_a: assert property (dma_low_priority)
    else $error("priority hint low");
  tx_req_fill_a: assert property (tx_dma_req && tx_dma_ack |=> !tx_dma_req)
    else $error("tx request stays");
  rx_req_pop_a: assert property (rx_dma_req && rx_dma_ack |=> !rx_dma_req)
    else $error("rx request stays");
  start_bit_a: assert property ($fell(serial_out) |-> start_low)
    else $error("start bit short");
endmodule
bind async_serial_port_with_dma async_serial_port_with_dma_sva sva (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .serial_out, .tx_dma_req, .tx_dma_ack, .rx_dma_req, .rx_dma_ack, .dma_low_priority
);

// ==== testbench/async_serial_port_with_dma_test.sv ====
`timescale 1ns/1ns
module async_serial_port_with_dma_test import uart_pkg::*;;
  logic aclk, aresetn, serial_in, serial_out, irq, dma_low_priority, autobaud_edge;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic tx_dma_req, tx_dma_ack, rx_dma_req, rx_dma_ack;
  logic [8:0] tx_dma_data, rx_dma_data;
  int n_fail, checks_done, n_edges;
  localparam int bt = 16;
  async_serial_port_with_dma #(.addr_width(8)) dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serial_in, .serial_out, .tx_dma_req,
    .tx_dma_ack, .tx_dma_data, .rx_dma_req, .rx_dma_ack, .rx_dma_data,
    .dma_low_priority, .autobaud_edge, .irq
  );
  serial_peer peer (.aclk, .line_from_dut(serial_out), .line_to_dut(serial_in));
  always #5 aclk = ~aclk;
  always @(negedge aclk) if (autobaud_edge === 1'b1) n_edges++;
  // ****
  // Bus and compare helpers
  // ****
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    @(negedge aclk);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int k = 0; k < 99; k++) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) break;
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int k = 0; k < 99; k++) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) break;
    end
    s_axi_rready <= 1'b0;
  endtask
  function automatic void mk(input logic [8:0] w, input logic [7:0] lc,
                             output logic [12:0] f, output int n);
    logic p;
    f = '1;
    f[0] = 1'b0;
    n = 1;
    p = ~lc[4];
    for (int i = 0; i < 5 + lc[1:0]; i++) begin
      f[n] = w[i];
      p ^= w[i];
      n++;
    end
    if (lc[5]) begin
      f[n] = w[8];
      p ^= w[8];
      n++;
    end
    if (lc[3]) begin
      f[n] = p;
      n++;
    end
    n += 1 + lc[2];
  endfunction
  // ****
  // Scenarios
  // ****
  task automatic duplex(input logic [7:0] lc, input logic [8:0] w, input int b);
    logic [12:0] f, e;
    logic [31:0] d, m;
    logic [1:0] r;
    int n;
    w[8] = lc[6];
    m = ((32'h1 << (5 + lc[1:0])) - 1) | {23'h0, lc[5], 8'h0};
    wr(addr_line_control, {24'h0, lc}, r);
    mk(w, lc, e, n);
    fork
      peer.recv(f, n, b);
      peer.send(e, n, b);
      wr(addr_data, {23'h0, w}, r);
    join
    check({19'h0, f}, {19'h0, e});
    rd(addr_data, d, r);
    check(d & m, {23'h0, w} & m);
  endtask
  task automatic test_regs;
    logic [31:0] d;
    logic [1:0] r;
    rd(addr_divisor_low, d, r);
    check(d, 32'h01);
    rd(addr_line_control, d, r);
    check(d, 32'h03);
    wr(addr_divisor_high, 32'ha5, r);
    rd(addr_divisor_high, d, r);
    check(d, 32'ha5);
    wr(addr_divisor_high, 32'h00, r);
    wr(8'h24, 32'h01, r);
    check(r, axi_slverr);
    rd(addr_int_mask, d, r);
    check(d, 32'h0);
    check(r, axi_okay);
    $display("registers done");
  endtask
  task automatic test_formats;
    logic [7:0] lcs [6] = '{8'h03, 8'h00, 8'h1e, 8'h0d, 8'h63, 8'h6f};
    logic [1:0] r;
    foreach (lcs[i]) duplex(lcs[i], 9'h0a5 ^ {1'b0, lcs[i]}, bt);
    wr(addr_divisor_low, 32'h03, r);
    duplex(8'h03, 9'h03c, 3 * bt);
    wr(addr_divisor_low, 32'h01, r);
    $display("formats done");
  endtask
  task automatic test_irq;
    logic [12:0] e;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    wr(addr_line_control, 32'h0b, r);
    wr(addr_int_status, 32'hf, r);
    wr(addr_int_mask, 32'h4, r);
    mk(9'h055, 8'h0b, e, n);
    e[9] = ~e[9];
    peer.send(e, n, bt);
    check(irq, 1'b1);
    wr(addr_int_status, 32'h6, r);
    check(irq, 1'b0);
    rd(addr_data, d, r);
    e[9] = ~e[9];
    peer.send(e, n, bt);
    rd(addr_int_status, d, r);
    check(d[2:1], 2'b01);
    check(irq, 1'b0);
    wr(addr_int_mask, 32'h0, r);
    $display("interrupts done");
  endtask
  task automatic test_dma;
    logic [12:0] f, e;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    wr(addr_line_control, 32'h03, r);
    wr(addr_control, 32'h0b, r);
    mk(9'h0c3, 8'h03, e, n);
    fork
      peer.recv(f, n, bt);
      peer.send(e, n, bt);
      begin
        for (int k = 0; k < 99 && !tx_dma_req; k++) @(negedge aclk);
        @(posedge aclk);
        tx_dma_ack <= 1'b1;
        tx_dma_data <= 9'h0c3;
        @(posedge aclk);
        tx_dma_ack <= 1'b0;
      end
    join
    check({19'h0, f}, {19'h0, e});
    check(n_edges, 32'd4);
    check({rx_dma_req, rx_dma_data}, 10'h2c3);
    @(posedge aclk);
    rx_dma_ack <= 1'b1;
    @(posedge aclk);
    rx_dma_ack <= 1'b0;
    @(negedge aclk);
    check(rx_dma_req, 1'b0);
    rd(addr_capture, d, r);
    check(d, 32'd64);
    wr(addr_control, 32'h0, r);
    $display("dma done");
  endtask
  initial begin
    repeat (30000) @(posedge aclk);
    n_fail++;
    $display("ERROR %0t: watchdog", $time);
    finish_test();
  end
  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, tx_dma_ack, rx_dma_ack} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, tx_dma_data} = '0;
    s_axi_wstrb = 4'hf;
    n_fail = 0;
    n_edges = 0;
    checks_done = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    test_regs();
    test_formats();
    test_irq();
    test_dma();
    finish_test();
  end
endmodule
